//--- src/ump_chan.sv
// one channel's serial engine: divider, transmitter, receiver, infrared coding
`timescale 1ns/1ns
module ump_chan (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        ir_mode,
	input  wire logic        tx_start,
	input  wire logic [7:0]  tx_data,
	input  wire logic [15:0] divisor,
	input  wire logic        serial_in,
	output logic             tx_busy,
	output logic             tx_done,
	output logic [7:0]       rx_data,
	output logic             rx_valid,
	output logic             serial_out
);
	logic [15:0] div_cnt;
	logic        tick;
	logic [9:0]  tx_shift;
	logic [3:0]  tx_sub, tx_bitn, rx_sub, rx_bitn;
	logic        rx_s1, rx_s2, rx_busy, seen, bit_val, smp;
	logic [7:0]  rx_shift;

	// ======================================================
	// 16x sample enable; divisor zero behaves like one
	assign tick = (div_cnt >= divisor - 16'h0001) || (divisor == 16'h0000);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) div_cnt <= 16'h0000;
		else div_cnt <= tick ? 16'h0000 : div_cnt + 16'h0001;
	end

	// ======================================================
	// transmitter: start, eight data bits lsb first, one stop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_busy  <= 1'b0;
			tx_done  <= 1'b0;
			tx_shift <= 10'h3ff;
			tx_sub   <= 4'h0;
			tx_bitn  <= 4'h0;
		end else begin
			tx_done <= 1'b0;
			if (tx_start && !tx_busy) begin
				tx_busy  <= 1'b1;
				tx_shift <= {1'b1, tx_data, 1'b0};
				tx_sub   <= 4'h0;
				tx_bitn  <= 4'h0;
			end else if (tx_busy && tick) begin
				tx_sub <= tx_sub + 4'h1;
				if (tx_sub == ump_pkg::SUB_LAST) begin
					tx_shift <= {1'b1, tx_shift[9:1]};
					tx_bitn  <= tx_bitn + 4'h1;
					if (tx_bitn == ump_pkg::FRAME_LAST) begin
						tx_busy <= 1'b0;
						tx_done <= 1'b1;
					end
				end
			end
		end
	end

	// line level: idle high in standard mode (also through reset),
	// idle low in infrared mode with a short high pulse per zero bit
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) serial_out <= 1'b1;
		else if (ir_mode)
			serial_out <= tx_busy && !tx_shift[0] && (tx_sub < ump_pkg::IR_PULSE);
		else serial_out <= !tx_busy || tx_shift[0];
	end

	// ======================================================
	// receiver: pin synchronised before any use
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_s1 <= 1'b1;
			rx_s2 <= 1'b1;
		end else begin
			rx_s1 <= serial_in;
			rx_s2 <= rx_s1;
		end
	end

	// infrared decode samples at bit end whether a pulse was seen
	assign smp     = tick && (rx_sub == (ir_mode ? ump_pkg::SUB_LAST : ump_pkg::SUB_MID));
	assign bit_val = ir_mode ? !seen : rx_s2;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_busy  <= 1'b0;
			rx_sub   <= 4'h0;
			rx_bitn  <= 4'h0;
			rx_shift <= 8'h00;
			rx_data  <= 8'h00;
			rx_valid <= 1'b0;
			seen     <= 1'b0;
		end else begin
			rx_valid <= 1'b0;
			if (!rx_busy) begin
				seen <= 1'b0;
				if (tick && (ir_mode ? rx_s2 : !rx_s2)) begin
					rx_busy <= 1'b1;
					rx_sub  <= 4'h0;
					rx_bitn <= 4'h0;
					seen    <= ir_mode;
				end
			end else if (tick) begin
				rx_sub <= rx_sub + 4'h1;
				if (rx_s2) seen <= 1'b1;
				if (rx_sub == ump_pkg::SUB_LAST) begin
					seen    <= 1'b0;
					rx_bitn <= rx_bitn + 4'h1;
				end
				if (smp) begin
					if (rx_bitn == 4'h0 && bit_val) rx_busy <= 1'b0; // false start
					else if (rx_bitn == ump_pkg::FRAME_LAST) begin
						rx_busy  <= 1'b0;
						rx_valid <= bit_val;
						rx_data  <= rx_shift;
					end else if (rx_bitn != 4'h0)
						rx_shift <= {bit_val, rx_shift[7:1]};
				end
			end
		end
	end
endmodule : ump_chan

//--- src/ump_pkg.sv
// constants shared by the serial and modem pin block
package ump_pkg;
	// ======================================================
	// register map: word index per channel, channel select bit
	localparam logic [2:0] REG_DATA = 3'h0;
	localparam logic [2:0] REG_IER  = 3'h1;
	localparam logic [2:0] REG_ISTS = 3'h2;
	localparam logic [2:0] REG_EFR  = 3'h3;
	localparam logic [2:0] REG_MCR  = 3'h4;
	localparam logic [2:0] REG_MSR  = 3'h5;
	localparam logic [2:0] REG_DIV  = 3'h6;
	localparam int         CH_BIT   = 5;
	// ======================================================
	// field positions
	localparam int MCR_DTR  = 0;
	localparam int MCR_RTS  = 1;
	localparam int MCR_OP2  = 3;
	localparam int MCR_IR   = 6;
	localparam int AUTO_RTS = 6;
	localparam int AUTO_CTS = 7;
	localparam int ST_RX    = 0;
	localparam int ST_TX    = 1;
	localparam int ST_CTS   = 2;
	localparam int ST_W     = 3;
	localparam int MI_CTS   = 0;
	localparam int MI_DSR   = 1;
	localparam int MI_CD    = 2;
	localparam int MI_RI    = 3;
	localparam int MSR_BUSY = 4;
	localparam int MSR_FULL = 5;
	// ======================================================
	// reset values and write masks
	localparam logic [7:0]  MCR_RESET = 8'h00;
	localparam logic [7:0]  IER_RESET = 8'h00;
	localparam logic [7:0]  EFR_RESET = 8'h00;
	localparam logic [15:0] DIV_RESET = 16'h0001;
	localparam logic [7:0]  IER_WMASK = 8'hc7;
	localparam logic [7:0]  EFR_WMASK = 8'hc0;
	// ======================================================
	// bit timing in ticks of the 16x sample enable; last frame bit as a bit index
	localparam logic [3:0] SUB_LAST   = 4'hf;
	localparam logic [3:0] SUB_MID    = 4'h7;
	localparam logic [3:0] IR_PULSE   = 4'h3;
	localparam logic [3:0] FRAME_LAST = 4'h9;
endpackage : ump_pkg

//--- src/ump_top.sv
// apb register file and modem pins for two serial channels
//
// Our own choices: register access over APB and the register offsets.
`timescale 1ns/1ns
// Notes on behaviour
// - standard mode: transmit idles high, also in reset
// - infrared mode: coded line, idle low
// - output-two set: drive interrupt, user pin low
// - output-two clear: interrupt floats, user pin high
// - output-two resets to zero
// - cts readable, or gates transmit when auto enabled
// - dsr, cd, ri readable only, no effect
// - terminal ready output per channel, software driven
// - channel b rx ready low while data held
module ump_top (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             serial_out_chan_a,
	output logic             serial_out_chan_b,
	input  wire logic        serial_in_chan_a,
	input  wire logic        serial_in_chan_b,
	output logic             request_to_send_n_a,
	output logic             request_to_send_n_b,
	input  wire logic        clear_to_send_n_a,
	input  wire logic        clear_to_send_n_b,
	output logic             terminal_ready_n_a,
	output logic             terminal_ready_n_b,
	input  wire logic        set_ready_n_a,
	input  wire logic        set_ready_n_b,
	input  wire logic        carrier_detect_n_a,
	input  wire logic        carrier_detect_n_b,
	input  wire logic        ring_indicator_n_a,
	input  wire logic        ring_indicator_n_b,
	output logic             user_output_two_n_a,
	output logic             user_output_two_n_b,
	output logic             irq_out_chan_a,
	output logic             irq_out_chan_a_oe,
	output logic             irq_out_chan_b,
	output logic             irq_out_chan_b_oe,
	output logic             rx_ready_n
);
	// ======================================================
	// apb decode: zero wait states, error on unmapped words
	logic       ch_sel;
	logic [2:0] idx;
	logic       mapped;
	logic       acc;
	logic       wr_en;
	logic       rd_en;
	logic [31:0] rd_val [2];
	logic [3:0]  modem_pin [2];
	logic [1:0]  rx_pin;
	logic [1:0]  tx_pin;
	logic [1:0]  rts_n;
	logic [1:0]  dtr_n;
	logic [1:0]  op2_n;
	logic [1:0]  irq;
	logic [1:0]  irq_oe;
	logic [1:0]  full;

	assign ch_sel  = paddr[ump_pkg::CH_BIT];
	assign idx     = paddr[4:2];
	assign mapped  = (paddr[7:6] == 2'h0) && (idx <= ump_pkg::REG_DIV) && (paddr[1:0] == 2'h0);
	assign acc     = psel && penable;
	assign pready  = acc;
	assign pslverr = acc && !mapped;
	assign wr_en   = acc && pwrite && mapped;
	assign rd_en   = acc && !pwrite && mapped;

	// read data is captured in the setup cycle so it comes from a flop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) prdata <= 32'h0000_0000;
		else if (psel && !penable && !pwrite)
			prdata <= mapped ? rd_val[ch_sel] : 32'h0000_0000;
	end

	// ======================================================
	// pin bundles so both channels share one generate body
	assign modem_pin[0] = {ring_indicator_n_a, carrier_detect_n_a, set_ready_n_a,
		clear_to_send_n_a};
	assign modem_pin[1] = {ring_indicator_n_b, carrier_detect_n_b, set_ready_n_b,
		clear_to_send_n_b};
	assign rx_pin = {serial_in_chan_b, serial_in_chan_a};

	assign serial_out_chan_a   = tx_pin[0];
	assign serial_out_chan_b   = tx_pin[1];
	assign request_to_send_n_a = rts_n[0];
	assign request_to_send_n_b = rts_n[1];
	assign terminal_ready_n_a  = dtr_n[0];
	assign terminal_ready_n_b  = dtr_n[1];
	assign user_output_two_n_a = op2_n[0];
	assign user_output_two_n_b = op2_n[1];
	assign irq_out_chan_a      = irq[0];
	assign irq_out_chan_b      = irq[1];
	assign irq_out_chan_a_oe   = irq_oe[0];
	assign irq_out_chan_b_oe   = irq_oe[1];
	// channel a has no rx ready pin here
	assign rx_ready_n = !full[1];

	// ======================================================
	// per channel registers and pin logic
	for (genvar i = 0; i < 2; i++) begin : g_ch
		logic [7:0]  modem_ctrl_reg;
		logic [7:0]  irq_enable_reg;
		logic [7:0]  enhanced_feature_reg;
		logic [15:0] divisor;
		logic [ump_pkg::ST_W-1:0] ists;
		logic [ump_pkg::ST_W-1:0] ev;
		logic [7:0]  rx_holding_reg;
		logic [7:0]  tx_hold;
		logic [7:0]  rx_byte;
		logic [3:0]  mi_s1;
		logic [3:0]  mi_s2;
		logic        cts_q;
		logic        tx_full;
		logic        rx_full;
		logic        tx_busy;
		logic        tx_done;
		logic        rx_valid;
		logic        cts_ok;
		logic        auto_cts;
		logic        auto_rts;
		logic        go;
		logic        here;
		logic        irq_q;

		assign here     = (ch_sel == 1'(i));
		assign auto_cts = enhanced_feature_reg[ump_pkg::AUTO_CTS]
			&& irq_enable_reg[ump_pkg::AUTO_CTS];
		assign auto_rts = enhanced_feature_reg[ump_pkg::AUTO_RTS]
			&& irq_enable_reg[ump_pkg::AUTO_RTS];
		// clear to send only holds back new characters, never one in flight
		assign cts_ok = !auto_cts || !mi_s2[ump_pkg::MI_CTS];
		assign go     = tx_full && !tx_busy && cts_ok;

		// modem inputs pass two flops; only cts ever steers logic
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				mi_s1 <= 4'hf;
				mi_s2 <= 4'hf;
				cts_q <= 1'b1;
			end else begin
				mi_s1 <= modem_pin[i];
				mi_s2 <= mi_s1;
				cts_q <= mi_s2[ump_pkg::MI_CTS];
			end
		end

		// control registers written by software
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				modem_ctrl_reg       <= ump_pkg::MCR_RESET;
				irq_enable_reg       <= ump_pkg::IER_RESET;
				enhanced_feature_reg <= ump_pkg::EFR_RESET;
				divisor              <= ump_pkg::DIV_RESET;
			end else if (wr_en && here) begin
				case (idx)
					ump_pkg::REG_MCR: modem_ctrl_reg <= pwdata[7:0];
					ump_pkg::REG_IER: irq_enable_reg <= pwdata[7:0] & ump_pkg::IER_WMASK;
					ump_pkg::REG_EFR:
						enhanced_feature_reg <= pwdata[7:0] & ump_pkg::EFR_WMASK;
					ump_pkg::REG_DIV: divisor <= pwdata[15:0];
					default: ;
				endcase
			end
		end

		// transmit holding: writes while full are dropped
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				tx_full <= 1'b0;
				tx_hold <= 8'h00;
			end else if (go) tx_full <= 1'b0;
			else if (wr_en && here && idx == ump_pkg::REG_DATA && !tx_full) begin
				tx_full <= 1'b1;
				tx_hold <= pwdata[7:0];
			end
		end

		// receive holding: a new byte beats a read clear in the same cycle
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				rx_full        <= 1'b0;
				rx_holding_reg <= 8'h00;
			end else if (rx_valid) begin
				rx_full        <= 1'b1;
				rx_holding_reg <= rx_byte;
			end else if (rd_en && here && idx == ump_pkg::REG_DATA)
				rx_full <= 1'b0;
		end

		// sticky events, cleared by reading them; a new event wins
		assign ev[ump_pkg::ST_RX]  = rx_valid;
		assign ev[ump_pkg::ST_TX]  = tx_done;
		assign ev[ump_pkg::ST_CTS] = cts_q != mi_s2[ump_pkg::MI_CTS];
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) ists <= '0;
			else if (rd_en && here && idx == ump_pkg::REG_ISTS) ists <= ev;
			else ists <= ists | ev;
		end

		// interrupt level registered to keep the pin glitch free
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) irq_q <= 1'b0;
			else irq_q <= |(ists & irq_enable_reg[ump_pkg::ST_W-1:0]);
		end

		// output-two bit picks between driving the interrupt and the user pin
		assign irq[i]    = irq_q;
		assign irq_oe[i] = modem_ctrl_reg[ump_pkg::MCR_OP2];
		assign op2_n[i]  = !modem_ctrl_reg[ump_pkg::MCR_OP2];
		assign dtr_n[i]  = !modem_ctrl_reg[ump_pkg::MCR_DTR];
		// auto rts only withdraws a request software already made
		assign rts_n[i]  = !(modem_ctrl_reg[ump_pkg::MCR_RTS]
			&& !(auto_rts && rx_full));
		assign full[i]   = rx_full;

		// read values; dsr, cd and ri are only reported here
		always_comb begin
			rd_val[i] = 32'h0000_0000;
			case (idx)
				ump_pkg::REG_DATA: rd_val[i][7:0] = rx_holding_reg;
				ump_pkg::REG_IER:  rd_val[i][7:0] = irq_enable_reg;
				ump_pkg::REG_ISTS: rd_val[i][ump_pkg::ST_W-1:0] = ists;
				ump_pkg::REG_EFR:  rd_val[i][7:0] = enhanced_feature_reg;
				ump_pkg::REG_MCR:  rd_val[i][7:0] = modem_ctrl_reg;
				ump_pkg::REG_MSR: begin
					rd_val[i][3:0] = ~mi_s2;
					rd_val[i][ump_pkg::MSR_BUSY] = tx_busy;
					rd_val[i][ump_pkg::MSR_FULL] = rx_full;
				end
				ump_pkg::REG_DIV:  rd_val[i][15:0] = divisor;
				default: rd_val[i] = 32'h0000_0000;
			endcase
		end

		// serial engine; infrared mode chosen by the control register
		ump_chan u_chan (
			.pclk       (pclk),
			.presetn    (presetn),
			.ir_mode    (modem_ctrl_reg[ump_pkg::MCR_IR]),
			.tx_start   (go),
			.tx_data    (tx_hold),
			.divisor    (divisor),
			.serial_in  (rx_pin[i]),
			.tx_busy    (tx_busy),
			.tx_done    (tx_done),
			.rx_data    (rx_byte),
			.rx_valid   (rx_valid),
			.serial_out (tx_pin[i])
		);
	end
endmodule : ump_top

//--- test/testbench.sv
// self-checking bench for the serial and modem pin block
`timescale 1ns/1ns
module testbench;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, rx_ready_n, err, ch;
	logic [7:0]  paddr, b;
	logic [31:0] pwdata, prdata, rd, v, res_val, exp_q[$];
	logic [3:0]  e, w;
	string       name_q[$];
	int          n, res_n, done_n, n_errors, check_count, seed;
	logic        serial_out_chan_a, serial_out_chan_b, serial_in_chan_a, serial_in_chan_b;
	logic        request_to_send_n_a, request_to_send_n_b, terminal_ready_n_a, terminal_ready_n_b;
	logic        user_output_two_n_a, user_output_two_n_b, irq_out_chan_a, irq_out_chan_b;
	logic        irq_out_chan_a_oe, irq_out_chan_b_oe, clear_to_send_n_a, clear_to_send_n_b;
	logic        set_ready_n_a, set_ready_n_b, carrier_detect_n_a, carrier_detect_n_b;
	logic        ring_indicator_n_a, ring_indicator_n_b;
	wire  [1:0]  so    = {serial_out_chan_b, serial_out_chan_a};
	wire  [1:0]  rts_n = {request_to_send_n_b, request_to_send_n_a};
	wire  [1:0]  dtr_n = {terminal_ready_n_b, terminal_ready_n_a};
	wire  [1:0]  op2_n = {user_output_two_n_b, user_output_two_n_a};
	wire  [1:0]  oe    = {irq_out_chan_b_oe, irq_out_chan_a_oe};
	ump_top u_dut (.*);
	ump_peer peer_a (.pclk(pclk), .line_from_dut(serial_out_chan_a), .line_to_dut(serial_in_chan_a));
	ump_peer peer_b (.pclk(pclk), .line_from_dut(serial_out_chan_b), .line_to_dut(serial_in_chan_b));
	// ======================================================
	// clock, watchdog, result monitor
	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end
	initial begin
		repeat (20000) @(posedge pclk);
		n_errors++;
		test_done();
	end
	task cmp(input string nm, input logic [31:0] ex, input logic [31:0] got);
		check_count++;
		if (got !== ex) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, ex, got);
		end
	endtask : cmp
	// oldest note is paired with the oldest result
	always @(posedge pclk) begin
		if (res_n != done_n) begin
			done_n++;
			cmp(name_q.pop_front(), exp_q.pop_front(), res_val);
		end
	end
	// a note carries what was seen first and what the rules expect second
	task chk(input string nm, input logic [31:0] got, input logic [31:0] ex);
		name_q.push_back(nm);
		exp_q.push_back(ex);
		res_val <= got;
		res_n   <= res_n + 1;
		@(posedge pclk);
	endtask : chk
	// one apb transfer; data and error taken at the access edge
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		psel    <= 1'b1;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd  = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		repeat (2) @(posedge pclk);
	endtask : apb
	task test_done;
		$display("checks %0d mismatches %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : test_done
	// ======================================================
	// main sequence
	initial begin
		seed = 32'hfd4f;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{clear_to_send_n_a, set_ready_n_a, carrier_detect_n_a, ring_indicator_n_a} = 4'hf;
		{clear_to_send_n_b, set_ready_n_b, carrier_detect_n_b, ring_indicator_n_b} = 4'hf;
		presetn = 1'b0;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		chk("tx idle", 32'(so), 32'h3);
		chk("op2 oe", 32'({op2_n, oe}), 32'hc);
		chk("dtr rts rdy", 32'({dtr_n, rts_n, rx_ready_n}), 32'h1f);
		$display("test reset done");
		// every output-two and rts combination on both channels
		for (int i = 0; i < 8; i++) begin
			ch = i[0];
			v = $random(seed) & 32'hb5;
			v[3] = i[1];
			v[1] = i[2];
			apb(1'b1, {2'b0, ch, 5'h10}, v);
			e = {~v[0], ~v[1], ~v[3], v[3]};
			chk("mcr", 32'({dtr_n[ch], rts_n[ch], op2_n[ch], oe[ch]}), 32'(e));
		end
		$display("test modem outputs done");
		// random modem inputs reach status, line stays idle
		for (int i = 0; i < 4; i++) begin
			ch = i[0];
			v = $random(seed);
			{clear_to_send_n_a, set_ready_n_a, carrier_detect_n_a, ring_indicator_n_a} <= v[3:0];
			{clear_to_send_n_b, set_ready_n_b, carrier_detect_n_b, ring_indicator_n_b} <= v[7:4];
			repeat (4) @(posedge pclk);
			apb(1'b0, {2'b0, ch, 5'h14}, 32'h0);
			w = ch ? v[7:4] : v[3:0];
			e = ~{w[0], w[1], w[2], w[3]};
			chk("msr", 32'(rd[3:0]), 32'(e));
			chk("line", 32'(so), 32'h3);
		end
		{clear_to_send_n_a, set_ready_n_a, carrier_detect_n_a, ring_indicator_n_a} <= 4'hf;
		{clear_to_send_n_b, set_ready_n_b, carrier_detect_n_b, ring_indicator_n_b} <= 4'hf;
		$display("test modem inputs done");
		// byte into b: auto rts, ready pin, interrupt raise, mask, clear
		apb(1'b1, 8'h30, 32'h0a); // rts set before auto rts
		apb(1'b1, 8'h2c, 32'h40);
		apb(1'b1, 8'h24, 32'h41);
		v = $random(seed) & 32'hff;
		peer_b.send(v[7:0]);
		for (int k = 0; k < 64 && rx_ready_n === 1'b1; k++) @(posedge pclk);
		repeat (2) @(posedge pclk);
		chk("rx full", 32'({rx_ready_n, rts_n[1], irq_out_chan_b, oe[1]}), 32'h7);
		apb(1'b1, 8'h24, 32'h40);
		chk("irq masked", 32'(irq_out_chan_b), 32'h0);
		apb(1'b1, 8'h24, 32'h41);
		apb(1'b0, 8'h20, 32'h0);
		chk("rx byte", 32'(rd[7:0]), v);
		chk("rx empty", 32'({rx_ready_n, rts_n[1], irq_out_chan_b}), 32'h5);
		apb(1'b0, 8'h28, 32'h0);
		chk("ists clear", 32'({rd[0], irq_out_chan_b}), 32'h2);
		$display("test receive done");
		// auto cts holds a byte until the peer clears it
		apb(1'b1, 8'h10, 32'h0);
		apb(1'b1, 8'h0c, 32'h80);
		apb(1'b1, 8'h04, 32'h80);
		v = $random(seed) & 32'hff;
		apb(1'b1, 8'h00, v);
		repeat (40) @(posedge pclk);
		chk("held", 32'(serial_out_chan_a), 32'h1);
		fork
			peer_a.catch(b);
			clear_to_send_n_a <= 1'b0;
		join
		chk("tx byte", 32'(b), v);
		repeat (40) @(posedge pclk);
		chk("tx idle", 32'(serial_out_chan_a), 32'h1);
		$display("test transmit done");
		// infrared: idle low, one fixed pulse for each zero bit
		apb(1'b1, 8'h10, 32'h40);
		chk("ir idle", 32'(serial_out_chan_a), 32'h0);
		v = $random(seed) & 32'hff;
		apb(1'b1, 8'h00, v);
		n = 0;
		repeat (200) begin
			@(posedge pclk);
			n += serial_out_chan_a;
		end
		chk("ir pulses", 32'(n), 32'((9 - $countones(v[7:0])) * ump_pkg::IR_PULSE));
		// unmask transmit done on a and hand the pin to the interrupt
		apb(1'b1, 8'h04, 32'h82);
		apb(1'b1, 8'h10, 32'h48);
		chk("irq a", 32'({irq_out_chan_a, irq_out_chan_a_oe}), 32'h3);
		$display("test infrared done");
		// unmapped word, then a second reset while in infrared mode
		apb(1'b0, 8'h1c, 32'h0);
		chk("unmapped", {err, rd[30:0]}, 32'h80000000);
		// divisor on b reads back; the reset below puts it back to one
		v = $random(seed) & 32'hffff;
		apb(1'b1, 8'h38, v);
		apb(1'b0, 8'h38, 32'h0);
		chk("divisor", rd, v);
		presetn <= 1'b0;
		@(posedge pclk);
		chk("pins in reset", 32'({so, oe}), 32'hc);
		presetn <= 1'b1;
		repeat (3) @(posedge pclk);
		$display("test errors and reset done");
		test_done();
	end
endmodule : testbench

//--- test/ump_asserts.sv
// concurrent pin checks for the serial and modem block
`timescale 1ns/1ns
module ump_asserts (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic        serial_out_chan_a,
	input wire logic        serial_out_chan_b,
	input wire logic        request_to_send_n_a,
	input wire logic        terminal_ready_n_a,
	input wire logic        user_output_two_n_a,
	input wire logic        user_output_two_n_b,
	input wire logic        irq_out_chan_a_oe,
	input wire logic        irq_out_chan_b_oe,
	input wire logic        rx_ready_n
);
	// ======================================================
	// accesses decoded at the access edge
	wire acc   = psel && penable;
	wire wr_a  = acc && pwrite && paddr == 8'h10;
	wire rd_bd = acc && !pwrite && paddr == 8'h20;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ======================================================
	// properties
	property p_op2_a; user_output_two_n_a == !irq_out_chan_a_oe; endproperty
	property p_op2_b; user_output_two_n_b == !irq_out_chan_b_oe; endproperty
	property p_rst_int;
		$rose(presetn) |-> !irq_out_chan_a_oe && !irq_out_chan_b_oe && user_output_two_n_a;
	endproperty
	property p_rst_tx;
		$rose(presetn) |-> serial_out_chan_a && serial_out_chan_b && rx_ready_n;
	endproperty
	property p_oe_wr; wr_a |=> irq_out_chan_a_oe == $past(pwdata[3]); endproperty
	property p_dtr_wr; wr_a |=> terminal_ready_n_a == !$past(pwdata[0]); endproperty
	property p_rts_off; wr_a && !pwdata[1] |=> request_to_send_n_a; endproperty
	property p_rxrdy; rd_bd |=> rx_ready_n; endproperty
	// coded line must fall to its idle level within a few clocks
	property p_ir; wr_a && pwdata[6] |-> ##[1:5] !serial_out_chan_a; endproperty
	a_op2_a: assert property (p_op2_a) else $error("op2 a vs irq enable");
	a_op2_b: assert property (p_op2_b) else $error("op2 b vs irq enable");
	a_rst_int: assert property (p_rst_int) else $error("irq pins after reset");
	a_rst_tx: assert property (p_rst_tx) else $error("tx pins after reset");
	a_oe_wr: assert property (p_oe_wr) else $error("irq enable not from mcr");
	a_dtr_wr: assert property (p_dtr_wr) else $error("dtr not inverse");
	a_rts_off: assert property (p_rts_off) else $error("rts low with bit clear");
	a_rxrdy: assert property (p_rxrdy) else $error("rx ready after read");
	a_ir: assert property (p_ir) else $error("ir line not idle low");
	c_ir: cover property (wr_a && pwdata[6]);
	c_rx: cover property ($fell(rx_ready_n));
	c_tx: cover property ($fell(serial_out_chan_a));
endmodule : ump_asserts
bind ump_top ump_asserts u_chk (.*);

//--- test/ump_peer.sv
// serial peer on one channel: sends and catches 8n1 frames
`timescale 1ns/1ns
module ump_peer (
	input  wire logic pclk,
	input  wire logic line_from_dut,
	output logic      line_to_dut
);
	int bit_clks = 16; // divisor of one gives sixteen clocks a bit
	// released line rests high, which the receiver relies on
	initial line_to_dut = 1'b1;
	// stop bit leaves the line high again
	task send(input logic [7:0] b);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			line_to_dut <= f[i];
			repeat (bit_clks) @(posedge pclk);
		end
	endtask : send
	// sample each bit in its middle, lsb first
	task catch(output logic [7:0] b);
		@(negedge line_from_dut);
		repeat (bit_clks / 2) @(posedge pclk);
		for (int i = 0; i < 8; i++) begin
			repeat (bit_clks) @(posedge pclk);
			b[i] = line_from_dut;
		end
	endtask : catch
endmodule : ump_peer
